//--- pkg/tasm_pkg.sv
// Package holding register map, field layout, timing and carrier types of the temperature alarm block.
// What this block does
// - Config3 bits 5,4 mask channels 6,5 overtemp
// - Config3 bits 3,0 mask channels 4,1; reset 0
// - Status1 bit 6 set on local high
// - Status1 bits 5..3 follow channels 6..4 high
// - Status1 bits 2..0 follow channels 3..1 high
// - Config1 bit 3 enables channel 1 cancellation
// - Cancellation lengthens channel 1 conversion 125ms
// - Open or shorted diode reports channel fault
// - Faulty remote channels skipped in sequence
// - Overtemp flags clear on status2 read only
// - Fault ends below threshold minus 4C
// - Config2 bits 6..0 mask warning outputs
// - Cleared warning reasserts after next conversion
package tasm_pkg;
  // Register offsets.
  localparam logic [7:0] OFS_CONFIG1 = 8'h41;
  localparam logic [7:0] OFS_CONFIG2 = 8'h42;
  localparam logic [7:0] OFS_CONFIG3 = 8'h43;
  localparam logic [7:0] OFS_STATUS1 = 8'h44;
  localparam logic [7:0] OFS_STATUS2 = 8'h45;
  localparam logic [7:0] OFS_STATUS3 = 8'h46;
  localparam logic [7:0] OFS_MFG_ID  = 8'h0A;
  // Arbitrary identification value, not tied to any maker.
  localparam logic [7:0] MFG_ID_VALUE = 8'h5_5;
  // Field layout and writable masks.
  localparam int          BIT_RES_CANCEL  = 3;
  localparam int          BIT_STANDBY     = 7;
  localparam logic [2:0]  CH_CANCEL       = 3'h1;
  localparam logic [2:0]  STATUS1_LOCAL   = 3'h6;
  localparam logic [7:0]  CONFIG1_WMASK   = 8'hF_8;
  localparam logic [7:0]  CONFIG2_WMASK   = 8'h7_F;
  localparam logic [7:0]  CONFIG3_WMASK   = 8'h3_9;
  localparam logic [7:0]  STATUS2_MASK    = 8'h3_9;
  localparam logic [7:0]  REG_RESET       = 8'h0_0;
  localparam logic [7:0]  HYST_DEG        = 8'h0_4;
  // Channel numbering: 0 local, 1..6 remote.
  localparam int          NUM_CH          = 7;
  localparam logic [2:0]  CH_LAST         = 3'h6;
  localparam logic [2:0]  CH_FIRST        = 3'h0;
  // Timing.
  localparam longint      CLK_HZ          = 20_000_000;
  localparam longint      CONV_US         = 10_000;
  localparam longint      RES_CANCEL_MS   = 125;
  localparam int          CONV_CYCLES     = int'(CLK_HZ * CONV_US / 1_000_000);
  localparam int          RES_CANCEL_CYCLES = int'(CLK_HZ * RES_CANCEL_MS / 1000);
  // Register access port.
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tasm_bus_type;
  // Converter result for one channel.
  typedef struct packed {
    logic       valid;
    logic [2:0] channel;
    logic [7:0] temp;
    logic       diodeFault;
  } tasm_conv_type;
endpackage

//--- rtl/tasm_channel_eval.sv
// Per-channel comparison with hysteresis for warning and overtemp limits.
`timescale 1ns/100ps
module tasm_channel_eval (
  input  wire logic [7:0] temp,
  input  wire logic [7:0] warnLimit,
  input  wire logic [7:0] otLimit,
  input  wire logic       warnActive,
  input  wire logic       otActive,
  output logic            warnCond,
  output logic            otCond
);
  import tasm_pkg::*;
  wire logic [8:0] warnRelease;
  wire logic [8:0] otRelease;
  // A condition once active holds until temp drops below limit minus hysteresis.
  assign warnRelease = {1'b0, warnLimit} - {1'b0, HYST_DEG};
  assign otRelease   = {1'b0, otLimit} - {1'b0, HYST_DEG};
  assign warnCond = (temp > warnLimit) || (warnActive && !warnRelease[8] && temp >= warnRelease[7:0]);
  assign otCond   = (temp > otLimit) || (otActive && !otRelease[8] && temp >= otRelease[7:0]);
endmodule // tasm_channel_eval

//--- rtl/tasm_status_mask.sv
// Alarm status flags, masks, conversion sequencer and output drive of the temperature monitor.
`timescale 1ns/100ps
module tasm_status_mask (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire tasm_pkg::tasm_bus_type  regBus,
  output logic [7:0]                   regRdata,
  input  wire tasm_pkg::tasm_conv_type convResult,
  input  wire logic [55:0]             warnLimits,
  input  wire logic [55:0]             otLimits,
  output logic                         convStart,
  output logic [2:0]                   convChannel,
  output logic                         convStandby,
  output logic                         alertOut,
  output logic                         alertOe,
  output logic                         overtempOutput,
  output logic                         overtempOe
);
  import tasm_pkg::*;

  // The sequencer asks for one conversion, waits for its result, adds the
  // cancellation time on channel 1 when enabled, then picks the next channel.
  typedef enum {SEQ_START, SEQ_WAIT, SEQ_EXTRA, SEQ_NEXT} tasm_seq_type;

  // Sequencer state.
  tasm_seq_type seqReg;
  tasm_seq_type seqNext;
  logic [2:0]   chanReg;
  logic [2:0]   chanNext;
  logic [31:0]  cntReg; // Wide enough for the cancellation wait at this clock rate.

  // Host-visible registers and the read data ahead of its output flop.
  logic [7:0]   config1Reg;
  logic [7:0]   config2Reg;
  logic [7:0]   config3Reg;
  logic [7:0]   status1Reg;
  logic [7:0]   status2Reg;
  logic [7:0]   status3Reg;
  logic [7:0]   rdataNext;

  // Live alarm conditions, bit k for channel k, kept between conversions.
  logic [6:0]   warnActReg;
  logic [6:0]   otActReg;

  // Register decode. Both strobes last one cycle, so a read clears its flags once.
  wire logic       isWrite1    = regBus.write && regBus.addr == OFS_CONFIG1;
  wire logic       isWrite2    = regBus.write && regBus.addr == OFS_CONFIG2;
  wire logic       isWrite3    = regBus.write && regBus.addr == OFS_CONFIG3;
  wire logic       readStatus1 = regBus.read && regBus.addr == OFS_STATUS1;
  wire logic       readStatus2 = regBus.read && regBus.addr == OFS_STATUS2;

  // Conversion bookkeeping. A result for any other channel, or one that arrives
  // while no conversion is pending, is ignored.
  wire logic       resCancel   = config1Reg[BIT_RES_CANCEL];
  wire logic       convDone    = convResult.valid && seqReg == SEQ_WAIT && convResult.channel == chanReg;
  wire logic       needExtra   = convDone && chanReg == CH_CANCEL && resCancel;
  wire logic [2:0] ch          = convResult.channel;

  // Per-channel vectors, bit k for channel k.
  wire logic [6:0] warnCondVec;
  wire logic [6:0] otCondVec;
  wire logic [6:0] warnMasked;
  wire logic [6:0] otMasked;
  wire logic [6:0] chanFaulted;

  // One comparator per channel; only channels 1,4,5,6 have overtemp limits in use.
  // All share the converter's temperature bus; only the one whose result is due is used.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_eval
      tasm_channel_eval u_eval (
        .temp       (convResult.temp),
        .warnLimit  (warnLimits[gi*8 +: 8]),
        .otLimit    (otLimits[gi*8 +: 8]),
        .warnActive (warnActReg[gi]),
        .otActive   (otActReg[gi]),
        .warnCond   (warnCondVec[gi]),
        .otCond     (otCondVec[gi])
      );
    end
  endgenerate

  // Overtemp output is gated by config3 masks on channels 6,5,4,1.
  // Config3 and status2 share one layout, bit k for remote channel k+1, so a mask
  // bit sits right beside the flag it gates. Channels without an overtemp limit
  // are held out by the status2 field mask.
  assign otMasked = {otActReg[6:1] & STATUS2_MASK[5:0] & ~config3Reg[5:0], 1'b0};
  // Warning output is gated by config2 masks.
  assign warnMasked = status1Reg[6:0] & ~config2Reg[6:0];
  // Faulted remote channels, indexed by channel number.
  assign chanFaulted = {status3Reg[6:1], 1'b0};

  // Next channel skips remote channels with a diode fault; local is never faulted.
  // The found flag matters: the local channel also has code zero, so testing the
  // choice against zero would pass over it after channel 6 and starve it.
  always_comb begin
    logic [2:0] c;
    logic       found;
    c = chanReg;
    found = 1'b0;
    chanNext = CH_FIRST;
    for (int k = 0; k < NUM_CH; k++) begin
      c = (c == CH_LAST) ? CH_FIRST : c + 3'h1;
      if (!found && !chanFaulted[c]) begin
        chanNext = c;
        found = 1'b1;
      end
    end
  end

  // Sequencer: start, wait for result, optional extra time, advance.
  // The extra wait holds the whole sequence, so every other channel is read less
  // often while cancellation is on; that is the price of the longer reading.
  always_comb begin
    seqNext = seqReg;
    unique case (seqReg)
      SEQ_START: seqNext = SEQ_WAIT;
      SEQ_WAIT:  if (convDone) begin
                   seqNext = needExtra ? SEQ_EXTRA : SEQ_NEXT;
                 end
      SEQ_EXTRA: if (cntReg == 32'(RES_CANCEL_CYCLES - 1)) begin
                   seqNext = SEQ_NEXT;
                 end
      SEQ_NEXT:  seqNext = SEQ_START;
    endcase
  end

  // Readback mux; reserved bits read zero.
  // The mux follows the address every cycle, so the flop holds the value seen at
  // the same edge at which a status read clears it.
  always_comb begin
    unique case (regBus.addr)
      OFS_CONFIG1: rdataNext = config1Reg;
      OFS_CONFIG2: rdataNext = config2Reg;
      OFS_CONFIG3: rdataNext = config3Reg;
      OFS_STATUS1: rdataNext = status1Reg;
      OFS_STATUS2: rdataNext = status2Reg;
      OFS_STATUS3: rdataNext = status3Reg;
      OFS_MFG_ID:  rdataNext = MFG_ID_VALUE;
      default:     rdataNext = REG_RESET;
    endcase
  end

  // Configuration writes keep only implemented bits.
  // Unimplemented bits are dropped on the way in, so readback needs no masking.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      config1Reg <= REG_RESET;
      config2Reg <= REG_RESET;
      config3Reg <= REG_RESET;
    end else begin
      if (isWrite1) config1Reg <= regBus.wdata & CONFIG1_WMASK;
      if (isWrite2) config2Reg <= regBus.wdata & CONFIG2_WMASK;
      if (isWrite3) config3Reg <= regBus.wdata & CONFIG3_WMASK;
    end
  end

  // Sequencer state, channel and extra-time counter.
  // The counter rests at zero outside the extra state, so each wait starts fresh.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seqReg  <= SEQ_START;
      chanReg <= CH_FIRST;
      cntReg  <= '0;
    end else begin
      seqReg <= seqNext;
      cntReg <= (seqReg == SEQ_EXTRA) ? cntReg + 32'h0000_0001 : '0;
      if (seqReg == SEQ_NEXT) chanReg <= chanNext;
    end
  end

  // Condition state is updated, and flags are set, only at the end of a conversion.
  // Status1 clears on read but sets again from a persisting condition at the next conversion end.
  // Status2 sticks until read; a set in the same cycle as the read wins.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      warnActReg <= '0;
      otActReg   <= '0;
      status1Reg <= REG_RESET;
      status2Reg <= REG_RESET;
      status3Reg <= REG_RESET;
    end else begin
      if (readStatus1) status1Reg <= REG_RESET;
      if (readStatus2) status2Reg <= REG_RESET;
      if (convDone) begin
        // A faulted diode reading is meaningless, so it never raises an alarm.
        if (ch != CH_FIRST) begin
          status3Reg[ch] <= convResult.diodeFault;
        end
        warnActReg[ch] <= warnCondVec[ch] && !convResult.diodeFault;
        otActReg[ch]   <= otCondVec[ch] && !convResult.diodeFault && STATUS2_MASK[ch - 3'h1];
        if (warnCondVec[ch] && !convResult.diodeFault) begin
          status1Reg[ch == CH_FIRST ? STATUS1_LOCAL : ch - 3'h1] <= 1'b1;
        end
        if (otCondVec[ch] && !convResult.diodeFault && ch != CH_FIRST && STATUS2_MASK[ch - 3'h1]) begin
          status2Reg[ch - 3'h1] <= 1'b1;
        end
      end
    end
  end

  // Output flops; open-drain pins pull low while the enable is high.
  // The data bits stay low; only the enables move.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdata       <= REG_RESET;
      convStart      <= 1'b0;
      convChannel    <= CH_FIRST;
      convStandby    <= 1'b0;
      alertOut       <= 1'b0;
      alertOe        <= 1'b0;
      overtempOutput <= 1'b0;
      overtempOe     <= 1'b0;
    end else begin
      regRdata       <= rdataNext;
      convStart      <= seqReg == SEQ_START;
      convChannel    <= chanReg;
      convStandby    <= config1Reg[BIT_STANDBY]; // Only reported; the sequencer runs on.
      alertOut       <= 1'b0;
      alertOe        <= |warnMasked;
      overtempOutput <= 1'b0;
      // The output follows the live condition, so a status2 read does not release it.
      overtempOe     <= |otMasked;
    end
  end
endmodule // tasm_status_mask

//--- tb/tasm_status_mask_props.sv
// Port checker of the alarm flag, mask and sequencing block.
`timescale 1ns/100ps
module tasm_status_mask_props import tasm_pkg::*; (
  input wire logic           clk,
  input wire logic           reset,
  input wire tasm_bus_type   regBus,
  input wire logic [7:0]     regRdata,
  input wire tasm_conv_type  convResult,
  input wire logic           convStart,
  input wire logic [2:0]     convChannel,
  input wire logic           alertOut,
  input wire logic           alertOe,
  input wire logic           overtempOutput,
  input wire logic           overtempOe
);
  logic [7:0] mask3Reg;
  logic       cancelReg;
  logic [7:0] faultReg;
  // Shadow copies, so masks, cancellation and skipped channels are known here.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask3Reg <= 8'h0_0;
      cancelReg <= 1'b0;
      faultReg <= 8'h0_0;
    end else begin
      if (regBus.write && regBus.addr == OFS_CONFIG3) mask3Reg <= regBus.wdata & CONFIG3_WMASK;
      if (regBus.write && regBus.addr == OFS_CONFIG1) cancelReg <= regBus.wdata[BIT_RES_CANCEL];
      if (convResult.valid && convResult.diodeFault) faultReg[convResult.channel] <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_alert_data_low: assert property (!alertOut) else $error("alert data not low");
  a_ot_data_low: assert property (!overtempOutput) else $error("overtemp data not low");
  a_start_one_cycle: assert property (convStart |=> !convStart) else $error("start too long");
  a_all_masked_quiet: assert property ((mask3Reg == CONFIG3_WMASK)[*3] |-> !overtempOe)
    else $error("masked overtemp drove pin");
  a_cfg3_reserved_zero: assert property (regBus.addr == OFS_CONFIG3 |=> regRdata[7:6] == 2'h0 && regRdata[2:1] == 2'h0)
    else $error("config3 reserved bit set");
  a_st1_reserved_zero: assert property (regBus.addr == OFS_STATUS1 |=> !regRdata[7])
    else $error("status1 reserved bit set");
  a_fault_ch_skipped: assert property (convStart |-> !faultReg[convChannel]) else $error("faulted channel converted");
  a_next_start_due: assert property (convResult.valid && convResult.channel == convChannel
    && !(cancelReg && convChannel == 3'h1) |-> ##[2:3] convStart) else $error("next start late");
  a_alert_has_cause: assert property ($rose(alertOe) |-> $past(convResult.valid, 2) || $past(regBus.write, 2))
    else $error("alert rose without cause");
  c_ot_rise: cover property ($rose(overtempOe));
  c_alert_rise: cover property ($rose(alertOe));
  c_fault_seen: cover property (faultReg != 8'h0_0);
endmodule // tasm_status_mask_props
bind tasm_status_mask tasm_status_mask_props u_props (.clk(clk), .reset(reset), .regBus(regBus),
  .regRdata(regRdata), .convResult(convResult), .convStart(convStart), .convChannel(convChannel),
  .alertOut(alertOut), .alertOe(alertOe), .overtempOutput(overtempOutput), .overtempOe(overtempOe));

//--- tb/tasm_conv_model.sv
// Converter stand-in answering each start with one result after a fixed delay.
`timescale 1ns/100ps
module tasm_conv_model import tasm_pkg::*; #(parameter int LAT = 4) (
  input wire logic          clk,
  input wire logic          reset,
  input wire logic          convStart,
  input wire logic [2:0]    convChannel,
  input wire logic [55:0]   temps,
  input wire logic [6:0]    faults,
  output tasm_conv_type     convResult
);
  int         cnt;
  logic [2:0] chReg;
  // Idle temperature toggles every cycle, so nothing can lean on a stale value.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      chReg <= 3'h0;
      convResult <= '0;
    end else begin
      convResult.valid <= 1'b0;
      convResult.temp <= ~convResult.temp;
      if (convStart) begin
        chReg <= convChannel;
        cnt <= LAT;
      end else if (cnt == 1) begin
        convResult <= '{1'b1, chReg, temps[chReg*8 +: 8], faults[chReg]};
        cnt <= 0;
      end else if (cnt > 1) cnt <= cnt - 1;
    end
  end
endmodule // tasm_conv_model

//--- tb/tasm_status_mask_test.sv
// Self-checking bench of the alarm flag and mask block.
`timescale 1ns/100ps
module tasm_status_mask_test;
  import tasm_pkg::*;
  logic clk = 1'b0, reset = 1'b1, start, aoe, ooe, stby, unusedA, unusedB;
  tasm_bus_type  bus = '0;
  tasm_conv_type res;
  logic [7:0] rdata, d;
  logic [2:0] ch;
  logic [55:0] wl = {7{8'hFF}}, ol = {7{8'hFF}}, temps = {7{8'h20}};
  logic [6:0] faults = 7'h0_0;
  int miscompares = 0, checks_done = 0, hits2 = 0;
  tasm_status_mask dut (.clk(clk), .reset(reset), .regBus(bus), .regRdata(rdata), .convResult(res),
    .warnLimits(wl), .otLimits(ol), .convStart(start), .convChannel(ch), .convStandby(stby),
    .alertOut(unusedA), .alertOe(aoe), .overtempOutput(unusedB), .overtempOe(ooe));
  tasm_conv_model model (.clk(clk), .reset(reset), .convStart(start), .convChannel(ch),
    .temps(temps), .faults(faults), .convResult(res));
  always #25 clk = ~clk;
  // Starts on channel 2 are counted to show it is skipped once faulted.
  always @(negedge clk) if (start && ch == 3'h2) hits2++;
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk) bus = '{1'b1, 1'b0, a, v};
    @(negedge clk) bus.write = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(negedge clk) bus = '{1'b0, 1'b1, a, 8'h0_0};
    @(negedge clk) bus.read = 1'b0;
    d = rdata;
  endtask
  // Waits for two passes of channel 0, so every live channel converts at least once.
  task sweep;
    int n, k;
    n = 0;
    for (k = 0; k < 2000 && n < 2; k++) begin
      @(negedge clk);
      if (start && ch == 3'h0) n++;
    end
    if (n < 2) begin
      miscompares++;
      print_verdict;
    end
  endtask
  task t_regs;
    // Cancellation is switched off again long before channel 1 first finishes.
    wr(OFS_CONFIG1, 8'h8_F); rd(OFS_CONFIG1); check(d, 8'h8_8);
    check({7'h0_0, stby}, 8'h0_1);
    wr(OFS_CONFIG1, 8'h0_0);
    rd(OFS_CONFIG3); check(d, REG_RESET);
    rd(OFS_STATUS1); check(d, REG_RESET);
    wr(OFS_CONFIG3, 8'hFF); rd(OFS_CONFIG3); check(d, CONFIG3_WMASK);
    wr(OFS_CONFIG3, 8'h0_0);
  endtask
  task t_warn;
    wl = {7{8'h50}}; temps = {7{8'h50}};
    sweep; rd(OFS_STATUS1); sweep; rd(OFS_STATUS1); check(d, 8'h0_0);
    temps = {7{8'h51}};
    sweep; rd(OFS_STATUS1); check(d, 8'h7_F);
    sweep; check({7'h0_0, aoe}, 8'h0_1);
    wr(OFS_CONFIG2, 8'h7_F); sweep; check({7'h0_0, aoe}, 8'h0_0);
    wr(OFS_CONFIG2, 8'h0_0);
    // Inside the hysteresis band the condition holds and keeps setting flags.
    temps = {7{8'h4D}};
    sweep; rd(OFS_STATUS1); sweep; rd(OFS_STATUS1); check(d, 8'h7_F);
    temps = {7{8'h4B}};
    sweep; rd(OFS_STATUS1); sweep; rd(OFS_STATUS1); check(d, 8'h0_0);
    sweep; check({7'h0_0, aoe}, 8'h0_0);
  endtask
  task t_overtemp;
    logic [2:0] chs [4];
    int         bits [4];
    chs = '{3'h1, 3'h4, 3'h5, 3'h6};
    bits = '{0, 3, 4, 5};
    ol = {7{8'h60}}; temps = {7{8'h61}};
    sweep; rd(OFS_STATUS2); check(d, STATUS2_MASK);
    rd(OFS_STATUS2); check({7'h0_0, ooe}, 8'h0_1);
    wr(OFS_CONFIG3, CONFIG3_WMASK); sweep; check({7'h0_0, ooe}, 8'h0_0);
    // Each mask bit alone must silence its own channel, the only one driven hot.
    for (int i = 0; i < 4; i++) begin
      temps = {7{8'h40}};
      temps[chs[i]*8 +: 8] = 8'h61;
      wr(OFS_CONFIG3, 8'h0_1 << bits[i]); rd(OFS_STATUS2);
      sweep; check({7'h0_0, ooe}, 8'h0_0);
      wr(OFS_CONFIG3, 8'h0_0); sweep; check({7'h0_0, ooe}, 8'h0_1);
      rd(OFS_STATUS2); check(d, 8'h0_1 << bits[i]);
    end
  endtask
  task t_fault;
    temps = {7{8'h20}}; faults = 7'h0_4;
    sweep; rd(OFS_STATUS3); check(d, 8'h0_4);
    hits2 = 0; sweep; check(hits2[7:0], 8'h0_0);
    // The host masks the faulted channel 2 warning, as it should after power-up.
    wr(OFS_CONFIG2, 8'h0_2);
    temps = {7{8'h51}}; rd(OFS_STATUS1);
    sweep; rd(OFS_STATUS1); check(d, 8'h7_D);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    t_regs;
    t_warn;
    t_overtemp;
    t_fault;
    print_verdict;
  end
endmodule // tasm_status_mask_test
